/* node_pkg.sv */
// Package with constants and types for the fieldbus node supervision block
package node_pkg;
  localparam int PORTS = 2;
  localparam int OUT_WIDTH = 16;
  localparam int CLK_HZ = 20000000;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;
  localparam int INIT_US = 10;
  localparam int INIT_CYCLES = (CLK_HZ / 1000000) * INIT_US;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_DIAG = 8'h10;
  localparam logic [7:0] ADDR_OUT = 8'h14;
  // Control register fields
  localparam int CTRL_TOOL0 = 0;
  localparam int CTRL_TOOL1 = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Event bits, shared by interrupt status and mask
  localparam int EV_PARAM_OK = 0;
  localparam int EV_CONFIG_OK = 1;
  localparam int EV_BUS_TIMEOUT = 2;
  localparam int EV_DEV_TIMEOUT = 3;
  localparam int EV_DIAG = 4;
  localparam int EV_WIDTH = 5;
  // Diagnosis bits per port: 0 config failed, 1 wrong connection, 2 disconnected
  localparam int DG_CFG_FAIL = 0;
  localparam int DG_WRONG = 1;
  localparam int DG_DISC = 2;
  localparam int DG_WIDTH = 3;
  // Indicator codes
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;
  localparam logic [1:0] LED_RED_FLASH = 2'h3;
  typedef enum logic [1:0] {
    INIT, AWAITING_PARAMETERS, AWAITING_CONFIGURATION, CYCLIC_EXCHANGE
  } phase_t;
endpackage

/* node_port_check.sv */
// Per-port configuration and connection check with tool change handling
`timescale 1ns/1ps
module node_port_check
  import node_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic startCheck,
  input wire logic running,
  input wire logic toolChange,
  input wire logic configured,
  input wire logic present,
  input wire logic otherBlocks,
  output logic blocksOther,
  output logic active,
  output logic mapped,
  output logic [DG_WIDTH-1:0] diag
);
  typedef struct packed {
    logic blocks;
    logic active;
    logic mapped;
    logic [DG_WIDTH-1:0] diag;
  } state_t;
  state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (startCheck) begin
      s_d = '0;
      if (toolChange) begin
        s_d.active = configured;
      end else if (configured && !present) begin
        s_d.diag[DG_CFG_FAIL] = 1'b1;
        s_d.blocks = 1'b1;
      end else if (!configured && present) begin
        s_d.diag[DG_WRONG] = 1'b1;
        s_d.blocks = 1'b1;
      end else begin
        s_d.active = configured;
        s_d.mapped = configured && present;
      end
    end else if (running) begin
      if (otherBlocks) begin
        s_d.active = 1'b0;
        s_d.mapped = 1'b0;
      end
      if (toolChange && s_q.active) begin
        s_d.mapped = present;
        s_d.diag[DG_DISC] = !present;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign blocksOther = s_q.blocks;
  assign active = s_q.active;
  assign mapped = s_q.mapped;
  assign diag = s_q.diag;
endmodule // node_port_check

/* fieldbus_node_state_failsafe.sv */
// Fieldbus node phase control, fail-state output policy, indicators and APB registers
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module fieldbus_node_state_failsafe
  import node_pkg::*;
#(
  parameter int FLASH_COUNT = FLASH_CYCLES,
  parameter int INIT_COUNT = INIT_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic failStateSwitchPin,
  input wire logic failStateForceOnPin,
  input wire logic [PORTS-1:0] devicePresentPin,
  input wire logic [PORTS-1:0] deviceTimeoutPin,
  input wire logic paramValid,
  input wire logic paramOk,
  input wire logic [PORTS-1:0] paramToolChange,
  input wire logic configValid,
  input wire logic [PORTS-1:0] configPorts,
  input wire logic busTimeout,
  input wire logic busFault,
  input wire logic commReset,
  input wire logic dataValid,
  input wire logic [OUT_WIDTH-1:0] dataOut,
  output logic [OUT_WIDTH-1:0] outputs,
  output logic [1:0] phase,
  output logic exchangeActive,
  output logic [PORTS-1:0] portMapped,
  output logic [1:0] busFaultIndicator,
  output logic [1:0] firstPortIndicator,
  output logic [1:0] secondPortIndicator,
  output logic irq
);
  localparam int FW = $clog2(FLASH_COUNT + 1);
  localparam int IW = $clog2(INIT_COUNT + 1);

  typedef struct packed {
    phase_t phase;
    logic [IW-1:0] initCnt;
    logic [FW-1:0] flashCnt;
    logic flash;
    logic busLost;
    logic [PORTS-1:0] toolChange;
    logic [OUT_WIDTH-1:0] outputs;
    logic [EV_WIDTH-1:0] irqStat;
    logic [EV_WIDTH-1:0] irqMask;
    logic [31:0] prdata;
    logic [1:0] swSync1;
    logic [1:0] swSync2;
    logic [PORTS-1:0] presSync1;
    logic [PORTS-1:0] presSync2;
    logic [PORTS-1:0] toSync1;
    logic [PORTS-1:0] toSync2;
  } state_t;
  state_t s_q, s_d;

  logic startCheck;
  logic running;
  logic [PORTS-1:0] blocksOther;
  logic [PORTS-1:0] portActive;
  logic [PORTS-1:0] mappedW;
  logic [DG_WIDTH-1:0] diagW [PORTS];
  logic [PORTS-1:0] devFault;
  logic [EV_WIDTH-1:0] events;
  logic apbWr;
  logic apbRd;
  logic addrOk;
  logic failHold;
  logic failOn;
  logic busDown;
  logic configMatch;
  logic anyDiag;

  assign startCheck = (s_q.phase == AWAITING_CONFIGURATION) && configValid;
  assign running = (s_q.phase == CYCLIC_EXCHANGE);

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gPort
      node_port_check uCheck (
        .ref_clk(ref_clk),
        .rst(rst),
        .startCheck(startCheck),
        .running(running),
        .toolChange(s_q.toolChange[g]),
        .configured(configPorts[g]),
        .present(s_q.presSync2[g]),
        .otherBlocks(blocksOther[PORTS-1-g]),
        .blocksOther(blocksOther[g]),
        .active(portActive[g]),
        .mapped(mappedW[g]),
        .diag(diagW[g])
      );
      assign devFault[g] = portActive[g] && s_q.toSync2[g];
    end
  endgenerate

  // Without tool change the configured set must equal what is attached
  always_comb begin
    configMatch = 1'b1;
    for (int i = 0; i < PORTS; i++) begin
      if (!s_q.toolChange[i] && (configPorts[i] != s_q.presSync2[i])) begin
        configMatch = 1'b0;
      end
    end
  end

  assign anyDiag = |{diagW[0], diagW[1]};
  assign failHold = s_q.swSync2[0];
  assign failOn = s_q.swSync2[1];
  assign busDown = busTimeout || busFault || commReset;
  assign addrOk = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK) ||
                  (paddr == ADDR_DIAG) || (paddr == ADDR_OUT);
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;

  always_comb begin
    events = '0;
    events[EV_PARAM_OK] = (s_q.phase == AWAITING_PARAMETERS) && paramValid && paramOk;
    events[EV_CONFIG_OK] = startCheck && configMatch;
    events[EV_BUS_TIMEOUT] = (s_q.phase != INIT) && busDown;
    events[EV_DEV_TIMEOUT] = running && (|devFault);
    events[EV_DIAG] = running && anyDiag;
  end

  always_comb begin
    s_d = s_q;
    s_d.swSync1 = {failStateForceOnPin, failStateSwitchPin};
    s_d.swSync2 = s_q.swSync1;
    s_d.presSync1 = devicePresentPin;
    s_d.presSync2 = s_q.presSync1;
    s_d.toSync1 = deviceTimeoutPin;
    s_d.toSync2 = s_q.toSync1;
    if (s_q.flashCnt == FW'(FLASH_COUNT - 1)) begin
      s_d.flashCnt = '0;
      s_d.flash = !s_q.flash;
    end else begin
      s_d.flashCnt = s_q.flashCnt + FW'(1);
    end
    case (s_q.phase)
      INIT: begin
        if (s_q.initCnt == IW'(INIT_COUNT - 1)) begin
          s_d.phase = AWAITING_PARAMETERS;
        end else begin
          s_d.initCnt = s_q.initCnt + IW'(1);
        end
      end
      AWAITING_PARAMETERS: begin
        if (busDown) begin
          s_d.phase = AWAITING_PARAMETERS;
        end else if (paramValid && paramOk) begin
          s_d.toolChange = paramToolChange;
          s_d.phase = AWAITING_CONFIGURATION;
          s_d.busLost = 1'b0;
        end
      end
      AWAITING_CONFIGURATION: begin
        if (busDown) begin
          s_d.phase = AWAITING_PARAMETERS;
        end else if (configValid && configMatch) begin
          s_d.phase = CYCLIC_EXCHANGE;
        end
      end
      CYCLIC_EXCHANGE: begin
        if (busDown) begin
          s_d.phase = AWAITING_PARAMETERS;
          s_d.busLost = 1'b1;
        end else if (dataValid && !(|devFault)) begin
          s_d.outputs = dataOut;
        end
      end
      default: s_d.phase = INIT;
    endcase
    // Fail-state action is taken in the cycle the fault is seen
    if ((running && busDown) || (running && (|devFault) && !busDown)) begin
      if (failHold) begin
        s_d.outputs = s_q.outputs;
      end else if (failOn && busDown) begin
        s_d.outputs = '1;
      end else begin
        s_d.outputs = '0;
      end
    end
    // Sticky events: a new event wins over a write-one-to-clear
    if (apbWr && paddr == ADDR_IRQ_STAT) begin
      s_d.irqStat = s_q.irqStat & ~pwdata[EV_WIDTH-1:0];
    end
    s_d.irqStat = s_d.irqStat | events;
    if (apbWr && paddr == ADDR_IRQ_MASK) begin
      s_d.irqMask = pwdata[EV_WIDTH-1:0];
    end
    if (apbWr && paddr == ADDR_CTRL && pwdata[CTRL_RESET]) begin
      s_d.phase = AWAITING_PARAMETERS;
    end
    if (apbRd) begin
      case (paddr)
        ADDR_CTRL: s_d.prdata = 32'(s_q.toolChange);
        ADDR_STATUS: s_d.prdata = 32'({s_q.flash, s_q.busLost, devFault, s_q.phase});
        ADDR_IRQ_STAT: s_d.prdata = 32'(s_q.irqStat);
        ADDR_IRQ_MASK: s_d.prdata = 32'(s_q.irqMask);
        ADDR_DIAG: s_d.prdata = running ? 32'({diagW[1], diagW[0]}) : 32'h0;
        ADDR_OUT: s_d.prdata = 32'(s_q.outputs);
        default: s_d.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // Indicator driving: port red on device timeout, bus flashes after loss
  function automatic logic [1:0] portLed(input logic act, input logic flt,
                                         input logic [DG_WIDTH-1:0] dg);
    if (flt || (|dg)) begin
      return LED_RED;
    end else if (act) begin
      return LED_GREEN;
    end
    return LED_OFF;
  endfunction

  always_comb begin
    firstPortIndicator = portLed(portActive[0] && running, devFault[0] && running, diagW[0]);
    secondPortIndicator = portLed(portActive[1] && running, devFault[1] && running, diagW[1]);
    if (s_q.busLost || (s_q.phase == AWAITING_CONFIGURATION)) begin
      // The code itself means flashing; the blink phase is only reported in status
      busFaultIndicator = LED_RED_FLASH;
    end else begin
      busFaultIndicator = LED_OFF;
    end
  end

  assign outputs = s_q.outputs;
  assign phase = s_q.phase;
  assign exchangeActive = running;
  assign portMapped = mappedW;
  assign irq = |(s_q.irqStat & s_q.irqMask);
  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
endmodule // fieldbus_node_state_failsafe

/* node_checker.sv */
// Port assertions for the node supervision block
`timescale 1ns/1ps
module node_checker
  import node_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic failStateSwitchPin,
  input logic failStateForceOnPin,
  input logic paramValid,
  input logic paramOk,
  input logic configValid,
  input logic busTimeout,
  input logic busFault,
  input logic commReset,
  input logic dataValid,
  input logic [OUT_WIDTH-1:0] outputs,
  input logic [1:0] phase,
  input logic exchangeActive,
  input logic [1:0] busFaultIndicator
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire down = busTimeout || busFault || commReset;
  // A register write may restart the link, so it is kept out of the advance check
  wire apbW = psel && penable && pwrite;
  wire cutOk = phase == 2'd3 && busTimeout && !dataValid;
  param_accept_a: assert property (
    phase == 2'd1 && paramValid && paramOk && !down && !apbW |=> phase == 2'd2)
    else $error("parameters not accepted");
  config_gate_a: assert property (
    $rose(phase == 2'd3) |-> $past(configValid) && $past(phase) == 2'd2)
    else $error("exchange without configuration");
  bus_restart_a: assert property (
    phase[1] && down |=> phase == 2'd1) else $error("no restart after bus loss");
  hw_init_a: assert property (
    disable iff (1'b0) rst |=> phase == 2'd0) else $error("reset did not reinitialise");
  exch_flag_a: assert property (
    exchangeActive == (phase == 2'd3)) else $error("exchange flag wrong");
  fail_off_a: assert property (
    cutOk && !failStateSwitchPin && !failStateForceOnPin |=> outputs == 16'h0000)
    else $error("outputs not cleared");
  fail_on_a: assert property (
    cutOk && !failStateSwitchPin && failStateForceOnPin |=> outputs == 16'hffff)
    else $error("outputs not set");
  fail_hold_a: assert property (
    cutOk && failStateSwitchPin |=> $stable(outputs)) else $error("outputs not held");
  bus_flash_a: assert property (
    cutOk |=> busFaultIndicator == LED_RED_FLASH) else $error("bus indicator not flashing");
  cover property (phase == 2'd3 && dataValid);
  cover property (cutOk && failStateSwitchPin);
  cover property (phase == 2'd2 && configValid);
endmodule // node_checker
bind fieldbus_node_state_failsafe node_checker chkInst (.*);

/* dp_master_model.sv */
// Behavioural fieldbus master facing the node's link side
`timescale 1ns/1ps
module dp_master_model
  import node_pkg::*;
(
  input wire logic ref_clk,
  output logic paramValid,
  output logic paramOk,
  output logic [PORTS-1:0] paramToolChange,
  output logic configValid,
  output logic [PORTS-1:0] configPorts,
  output logic busTimeout,
  output logic busFault,
  output logic commReset,
  output logic dataValid,
  output logic [OUT_WIDTH-1:0] dataOut
);
  initial begin
    {paramValid, paramOk, paramToolChange, configValid, configPorts} = '0;
    {busTimeout, busFault, commReset, dataValid, dataOut} = '0;
  end
  // Released payload lines show the inverse of the last value, never a stale copy; fault lines return to zero
  task automatic send_param(input logic ok, input logic [PORTS-1:0] tc);
    @(posedge ref_clk);
    {paramValid, paramOk, paramToolChange} <= {1'b1, ok, tc};
    @(posedge ref_clk);
    {paramValid, paramOk, paramToolChange} <= {1'b0, ~ok, ~tc};
  endtask
  task automatic send_config(input logic [PORTS-1:0] p);
    @(posedge ref_clk);
    {configValid, configPorts} <= {1'b1, p};
    @(posedge ref_clk);
    {configValid, configPorts} <= {1'b0, ~p};
  endtask
  task automatic send_data(input logic [OUT_WIDTH-1:0] d);
    @(posedge ref_clk);
    {dataValid, dataOut} <= {1'b1, d};
    @(posedge ref_clk);
    {dataValid, dataOut} <= {1'b0, ~d};
  endtask
  task automatic fault(input logic [2:0] k);
    @(posedge ref_clk);
    {busTimeout, busFault, commReset} <= k;
    @(posedge ref_clk);
    {busTimeout, busFault, commReset} <= 3'b000;
  endtask
endmodule // dp_master_model

/* fieldbus_node_state_failsafe_tb_top.sv */
// Self-checking bench for the node supervision block
`timescale 1ns/1ps
module fieldbus_node_state_failsafe_tb_top
  import node_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic failStateSwitchPin, failStateForceOnPin;
  logic [PORTS-1:0] devicePresentPin, deviceTimeoutPin;
  logic [PORTS-1:0] paramToolChange, configPorts, portMapped;
  logic paramValid, paramOk, configValid, busTimeout, busFault, commReset, dataValid;
  logic exchangeActive, irq;
  logic [OUT_WIDTH-1:0] dataOut, outputs;
  logic [1:0] phase, busFaultIndicator, firstPortIndicator, secondPortIndicator;
  int numErrors = 0, totalChecks = 0;
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {failStateSwitchPin, failStateForceOnPin} = 2'b00;
    devicePresentPin = 2'b11;
    deviceTimeoutPin = 2'b00;
  end
  always #25 ref_clk = ~ref_clk;
  // Short counts keep the indicator and start-up waits to a few cycles
  fieldbus_node_state_failsafe #(.FLASH_COUNT(4), .INIT_COUNT(2)) DUT (.*);
  dp_master_model master (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic expect_phase(input logic [1:0] p);
    int n;
    n = 0;
    settle(1);
    while (phase !== p && n < 20) begin
      settle(1);
      n++;
    end
    chk(phase, p);
  endtask
  task automatic bring_up(input logic [PORTS-1:0] tc, input logic [PORTS-1:0] p);
    master.send_param(1'b1, tc);
    expect_phase(AWAITING_CONFIGURATION);
    master.send_config(p);
    expect_phase(CYCLIC_EXCHANGE);
  endtask
  task automatic t_reset;
    settle(1);
    chk(phase, INIT);
    expect_phase(AWAITING_PARAMETERS);
    chk({irq, exchangeActive, outputs}, 0);
    $display("t_reset done");
  endtask
  task automatic t_startup;
    master.send_param(1'b0, 2'b00);
    settle(3);
    chk(phase, AWAITING_PARAMETERS);
    master.send_param(1'b1, 2'b00);
    expect_phase(AWAITING_CONFIGURATION);
    master.send_config(2'b01);
    settle(3);
    chk(phase, AWAITING_CONFIGURATION);
    master.send_config(2'b11);
    expect_phase(CYCLIC_EXCHANGE);
    master.send_data(16'h5a3c);
    settle(1);
    chk(outputs, 16'h5a3c);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    chk(rd[1:0], 2'b11);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    settle(1);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    settle(1);
    chk(irq, 1'b0);
    apb(1'b0, 8'h20, 0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("t_startup done");
  endtask
  task automatic t_bus_fail;
    master.fault(3'b100);
    settle(1);
    chk(outputs, 16'h0000);
    chk(busFaultIndicator, LED_RED_FLASH);
    chk(phase, AWAITING_PARAMETERS);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    settle(1);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    settle(1);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    settle(1);
    chk(irq, 1'b0);
    $display("t_bus_fail done");
  endtask
  task automatic t_hold;
    @(posedge ref_clk);
    failStateSwitchPin <= 1'b1;
    bring_up(2'b00, 2'b11);
    master.send_data(16'h1234);
    master.fault(3'b010);
    settle(1);
    chk(outputs, 16'h1234);
    @(posedge ref_clk);
    {failStateSwitchPin, failStateForceOnPin} <= 2'b01;
    bring_up(2'b00, 2'b11);
    master.fault(3'b100);
    settle(1);
    chk(outputs, 16'hffff);
    @(posedge ref_clk);
    failStateForceOnPin <= 1'b0;
    $display("t_hold done");
  endtask
  task automatic t_device;
    bring_up(2'b00, 2'b11);
    master.send_data(16'h00ff);
    deviceTimeoutPin <= 2'b01;
    settle(5);
    chk(outputs, 16'h0000);
    chk({firstPortIndicator, busFaultIndicator}, {LED_RED, LED_OFF});
    @(posedge ref_clk);
    deviceTimeoutPin <= 2'b00;
    apb(1'b1, ADDR_CTRL, 32'h1);
    expect_phase(AWAITING_PARAMETERS);
    bring_up(2'b00, 2'b11);
    master.fault(3'b001);
    expect_phase(AWAITING_PARAMETERS);
    $display("t_device done");
  endtask
  task automatic t_tool;
    @(posedge ref_clk);
    devicePresentPin <= 2'b10;
    settle(4);
    bring_up(2'b01, 2'b11);
    chk(portMapped[0], 1'b0);
    @(posedge ref_clk);
    devicePresentPin <= 2'b11;
    settle(5);
    chk(portMapped[0], 1'b1);
    @(posedge ref_clk);
    devicePresentPin <= 2'b10;
    settle(5);
    apb(1'b0, ADDR_DIAG, 0);
    chk(rd[DG_DISC], 1'b1);
    @(posedge ref_clk);
    devicePresentPin <= 2'b11;
    settle(5);
    apb(1'b0, ADDR_DIAG, 0);
    chk(rd[DG_DISC], 1'b0);
    apb(1'b0, ADDR_CTRL, 0);
    chk(rd[1:0], 2'b01);
    // Mid-run hardware restart must pass through initialisation again
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    settle(1);
    chk(phase, INIT);
    expect_phase(AWAITING_PARAMETERS);
    $display("t_tool done");
  endtask
  task automatic reportAndStop;
    $display("Checks %0d, errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    reportAndStop;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_startup;
    t_bus_fail;
    t_hold;
    t_device;
    t_tool;
    reportAndStop;
  end
endmodule // fieldbus_node_state_failsafe_tb_top
